// *** uart_rx_cfg.svh ***
// register map, field positions, reset values and timing counts
`ifndef UART_RX_CFG_SVH
`define UART_RX_CFG_SVH

`define ADDR_W 8
`define DATA_W 8
`define DIV_W 10
`define EVT_W 3

`define A_IRQ_FLAGS 8'h0c
`define A_RX_CTRL 8'h18
`define A_RX_DATA 8'h1a
`define A_IRQ_EN 8'h8c
`define A_TX_CTRL 8'h98
`define A_BAUD_DIV 8'h99
`define A_EVT_STAT 8'h20
`define A_EVT_MASK 8'h21

`define B_RECEIVE_BUFFER_FULL_FLAG 5
`define B_RECEIVE_INTERRUPT_ENABLE 5
`define B_SERIAL_PORT_ENABLE 7
`define B_RX9 6
`define B_CONTINUOUS_RECEIVE_ENABLE 4
`define B_ADDRESS_DETECT_ENABLE 3
`define B_FRAMING_ERROR 2
`define B_OVERRUN_ERROR 1
`define B_NINTH_RECEIVED_BIT 0
`define B_HIGH_BAUD_SELECT 2

`define E_FRAME 0
`define E_OVR 1
`define E_FRAMING_ERROR 2

`define RX_CTRL_WMASK 8'hf8
`define TX_CTRL_WMASK 8'hf5
`define R_TX_CTRL 8'h02
`define R_ZERO 8'h00

`define MID_SAMPLE 4'h7
`define LAST_SAMPLE 4'hf
`define LAST_BIT8 4'h7
`define LAST_BIT9 4'h8
`define FIFO_FULL 2'h2

`endif

// *** uart_rx_pkg.sv ***
// types of the serial receiver
`include "uart_rx_cfg.svh"

package uart_rx_pkg;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} rx_state_e;

	typedef struct packed {
		logic framing_error;
		logic bit9;
		logic [7:0] data;
	} rx_entry_s;

	typedef struct packed {
		logic sync1;
		logic sync2;
		rx_state_e rx_st;
		logic [`DIV_W-1:0] div;
		logic [3:0] tick_cnt;
		logic [3:0] nbit;
		logic [8:0] receive_shift_register;
		rx_entry_s [1:0] fifo;
		logic head;
		logic [1:0] cnt;
		logic overrun_error;
		logic [7:0] rx_ctrl;
		logic [7:0] irq_en;
		logic [7:0] tx_ctrl;
		logic [7:0] baud_div;
		logic [`EVT_W-1:0] evt_stat;
		logic [`EVT_W-1:0] evt_mask;
		logic [7:0] rd_data;
		logic irq;
	} state_s;

endpackage : uart_rx_pkg

// *** uart_rx.sv ***
// asynchronous serial receiver with two-deep buffer and address detect
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_cfg.svh"

// Function
// - oversample at x16, shift once per bit
// - accept frames only while reception enabled
// - stop bit moves word to buffer, sets flag
// - receive flag interrupts only when enabled
// - flag read-only, clears when buffer emptied
// - receive buffer is two entries deep
// - third stop with buffer full sets overrun
// - overrun cleared only by toggling reception enable
// - overrun blocks all transfers into buffer
// - zero stop bit sets framing error
// - framing and ninth bit queued per byte
// - nine-bit mode stores ninth received bit
// - address mode keeps only ninth-bit-one frames
// - dropped data frame overwritten by next
// - address detect ignored outside nine-bit mode
module uart_rx (
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic CE,
	input wire logic [`ADDR_W-1:0] ADDR,
	input wire logic [`DATA_W-1:0] WR_DATA,
	input wire logic WR_EN,
	input wire logic RD_EN,
	output logic [`DATA_W-1:0] RD_DATA,
	input wire logic RX,
	output logic IRQ
);

	// ****************************************
	// state
	// ****************************************
	localparam uart_rx_pkg::state_s RST_STATE = '{
		sync1: 1'b1,
		sync2: 1'b1,
		rx_st: uart_rx_pkg::RX_IDLE,
		tx_ctrl: `R_TX_CTRL,
		default: '0
	};

	uart_rx_pkg::state_s s_reg;
	uart_rx_pkg::state_s s_next;
	uart_rx_pkg::rx_entry_s entry;
	uart_rx_pkg::rx_entry_s head_e;
	logic tick;
	logic stop_now;
	logic push;
	logic pop;
	logic ovr;
	logic addr_drop;
	logic rx_on;
	logic nine;
	logic addr_mode;
	logic widx;
	logic [`DIV_W-1:0] reload;
	logic [7:0] rmux;
	logic [`EVT_W-1:0] ev;
	logic [`EVT_W-1:0] wclr;

	assign RD_DATA = s_reg.rd_data;
	assign IRQ = s_reg.irq;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_next = s_reg;
		tick = 1'b0;
		stop_now = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		ovr = 1'b0;
		addr_drop = 1'b0;
		ev = '0;
		wclr = '0;
		rmux = `R_ZERO;
		head_e = s_reg.fifo[s_reg.head];

		// pin passes two flops before the receiver looks at it
		s_next.sync1 = RX;
		s_next.sync2 = s_reg.sync1;

		// high speed: clk/(X+1) per x16 tick; low speed four times slower
		if (s_reg.tx_ctrl[`B_HIGH_BAUD_SELECT]) begin
			reload = {2'b00, s_reg.baud_div};
		end else begin
			reload = {s_reg.baud_div, 2'b11};
		end
		if (s_reg.div == '0) begin
			tick = 1'b1;
			s_next.div = reload;
		end else begin
			s_next.div = s_reg.div - `DIV_W'(1);
		end

		rx_on = s_reg.rx_ctrl[`B_SERIAL_PORT_ENABLE] & s_reg.rx_ctrl[`B_CONTINUOUS_RECEIVE_ENABLE];
		nine = s_reg.rx_ctrl[`B_RX9];
		addr_mode = nine & s_reg.rx_ctrl[`B_ADDRESS_DETECT_ENABLE];

		unique case (s_reg.rx_st)
			uart_rx_pkg::RX_IDLE: begin
				// restart the divider on the falling edge to centre samples
				if (!s_reg.sync2) begin
					s_next.rx_st = uart_rx_pkg::RX_START;
					s_next.tick_cnt = '0;
					s_next.div = reload;
				end
			end
			uart_rx_pkg::RX_START: begin
				if (tick) begin
					s_next.tick_cnt = s_reg.tick_cnt + 4'h1;
					if (s_reg.tick_cnt == `MID_SAMPLE) begin
						// a glitch shorter than half a bit is not a start
						if (s_reg.sync2) begin
							s_next.rx_st = uart_rx_pkg::RX_IDLE;
						end else begin
							s_next.rx_st = uart_rx_pkg::RX_DATA;
							s_next.tick_cnt = '0;
							s_next.nbit = '0;
						end
					end
				end
			end
			uart_rx_pkg::RX_DATA: begin
				if (tick) begin
					s_next.tick_cnt = s_reg.tick_cnt + 4'h1;
					if (s_reg.tick_cnt == `LAST_SAMPLE) begin
						s_next.receive_shift_register = {s_reg.sync2, s_reg.receive_shift_register[8:1]};
						s_next.nbit = s_reg.nbit + 4'h1;
						if (s_reg.nbit == (nine ? `LAST_BIT9 : `LAST_BIT8)) begin
							s_next.rx_st = uart_rx_pkg::RX_STOP;
						end
					end
				end
			end
			uart_rx_pkg::RX_STOP: begin
				if (tick) begin
					s_next.tick_cnt = s_reg.tick_cnt + 4'h1;
					if (s_reg.tick_cnt == `LAST_SAMPLE) begin
						stop_now = 1'b1;
						s_next.rx_st = uart_rx_pkg::RX_IDLE;
					end
				end
			end
		endcase

		// ****************************************
		// frame delivery
		// ****************************************
		entry.framing_error = ~s_reg.sync2;
		entry.bit9 = nine & s_reg.receive_shift_register[8];
		entry.data = nine ? s_reg.receive_shift_register[7:0] : s_reg.receive_shift_register[8:1];
		if (stop_now) begin
			ev[`E_FRAMING_ERROR] = ~s_reg.sync2;
			if (addr_mode && !s_reg.receive_shift_register[8]) begin
				// data frame left in the shifter, next frame overwrites it
				addr_drop = 1'b1;
			end else if (s_reg.overrun_error) begin
				push = 1'b0;
			end else if (s_reg.cnt == `FIFO_FULL) begin
				ovr = 1'b1;
			end else begin
				push = 1'b1;
			end
		end
		ev[`E_FRAME] = push;
		ev[`E_OVR] = ovr;
		if (ovr) begin
			s_next.overrun_error = 1'b1;
		end

		// ****************************************
		// register reads
		// ****************************************
		if (RD_EN) begin
			unique case (ADDR)
				`A_IRQ_FLAGS: rmux[`B_RECEIVE_BUFFER_FULL_FLAG] = (s_reg.cnt != 2'h0);
				`A_RX_CTRL: begin
					rmux = s_reg.rx_ctrl & `RX_CTRL_WMASK;
					rmux[`B_FRAMING_ERROR] = (s_reg.cnt != 2'h0) & head_e.framing_error;
					rmux[`B_OVERRUN_ERROR] = s_reg.overrun_error;
					rmux[`B_NINTH_RECEIVED_BIT] = (s_reg.cnt != 2'h0) & head_e.bit9;
				end
				`A_RX_DATA: begin
					if (s_reg.cnt != 2'h0) begin
						rmux = head_e.data;
						pop = 1'b1;
					end
				end
				`A_IRQ_EN: rmux = s_reg.irq_en;
				`A_TX_CTRL: rmux = s_reg.tx_ctrl;
				`A_BAUD_DIV: rmux = s_reg.baud_div;
				`A_EVT_STAT: rmux = {5'h00, s_reg.evt_stat};
				`A_EVT_MASK: rmux = {5'h00, s_reg.evt_mask};
				default: rmux = `R_ZERO;
			endcase
		end
		s_next.rd_data = rmux;

		// ****************************************
		// two-entry buffer
		// ****************************************
		widx = s_reg.head ^ s_reg.cnt[0];
		if (push) begin
			s_next.fifo[widx] = entry;
		end
		if (pop) begin
			s_next.head = ~s_reg.head;
		end
		s_next.cnt = s_reg.cnt + {1'b0, push} - {1'b0, pop};

		// ****************************************
		// register writes
		// ****************************************
		if (WR_EN) begin
			unique case (ADDR)
				`A_RX_CTRL: s_next.rx_ctrl = WR_DATA & `RX_CTRL_WMASK;
				`A_IRQ_EN: s_next.irq_en = WR_DATA;
				`A_TX_CTRL: begin
					s_next.tx_ctrl = (WR_DATA & `TX_CTRL_WMASK) | `R_TX_CTRL;
				end
				`A_BAUD_DIV: s_next.baud_div = WR_DATA;
				`A_EVT_STAT: wclr = WR_DATA[`EVT_W-1:0];
				`A_EVT_MASK: s_next.evt_mask = WR_DATA[`EVT_W-1:0];
				default: wclr = '0;
			endcase
		end

		// clearing reception resets the receive logic and the overrun
		if (!rx_on) begin
			s_next.rx_st = uart_rx_pkg::RX_IDLE;
			s_next.overrun_error = 1'b0;
		end

		// a new event in the clearing cycle survives the clear
		s_next.evt_stat = (s_reg.evt_stat & ~wclr) | ev;

		s_next.irq = ((s_next.cnt != 2'h0) & s_next.irq_en[`B_RECEIVE_INTERRUPT_ENABLE])
			| (|(s_next.evt_stat & s_next.evt_mask));
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			s_reg <= RST_STATE;
		end else if (CE) begin
			s_reg <= s_next;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RESET);

	a_fifo_depth: assert property (s_reg.cnt <= `FIFO_FULL)
		else $error("buffer holds more than two entries");

	a_continuous_receive_enable_gates: assert property (
		(CE && !s_reg.rx_ctrl[`B_CONTINUOUS_RECEIVE_ENABLE])
		|=> s_reg.rx_st == uart_rx_pkg::RX_IDLE)
		else $error("receiver active while reception disabled");

	a_overrun_error_clear: assert property (
		(CE && !s_reg.rx_ctrl[`B_CONTINUOUS_RECEIVE_ENABLE]) |=> !s_reg.overrun_error)
		else $error("overrun not cleared by disabling reception");

	a_overrun_error_hold: assert property (
		(s_reg.overrun_error && s_reg.rx_ctrl[`B_CONTINUOUS_RECEIVE_ENABLE] && s_reg.rx_ctrl[`B_SERIAL_PORT_ENABLE]
		&& !(WR_EN && ADDR == `A_RX_CTRL)) |=> s_reg.overrun_error)
		else $error("overrun cleared without reception reset");

	a_overrun_error_blocks: assert property (
		(CE && s_reg.overrun_error) |=> s_reg.cnt <= $past(s_reg.cnt))
		else $error("buffer loaded while overrun set");

	a_push_flag: assert property (
		(CE && stop_now && !addr_drop && !s_reg.overrun_error
		&& s_reg.cnt != `FIFO_FULL)
		|=> s_reg.cnt != 2'h0 ##0 s_reg.evt_stat[`E_FRAME])
		else $error("frame not delivered after stop bit");

	a_overrun_set: assert property (
		(CE && stop_now && !addr_drop && s_reg.cnt == `FIFO_FULL
		&& rx_on && !(WR_EN && ADDR == `A_RX_CTRL))
		|=> s_reg.overrun_error && s_reg.cnt == `FIFO_FULL - {1'b0, $past(pop)})
		else $error("overrun missed on full buffer");

	a_addr_drop: assert property (
		(CE && stop_now && addr_mode && !s_reg.receive_shift_register[8])
		|=> s_reg.cnt <= $past(s_reg.cnt) && !$past(push))
		else $error("data frame loaded in address mode");

	a_framing_error_event: assert property (
		(CE && stop_now && !s_reg.sync2) |=> s_reg.evt_stat[`E_FRAMING_ERROR])
		else $error("zero stop bit not reported");

	a_receive_buffer_full_flag_clear: assert property (
		(CE && RD_EN && ADDR == `A_RX_DATA && s_reg.cnt == 2'h1 && !push)
		|=> s_reg.cnt == 2'h0 ##1 !s_reg.irq || s_reg.evt_stat != '0)
		else $error("receive flag not cleared when emptied");

	a_irq_gate: assert property (
		(!s_reg.irq_en[`B_RECEIVE_INTERRUPT_ENABLE] && (s_reg.evt_stat & s_reg.evt_mask) == '0)
		|-> !IRQ)
		else $error("interrupt without enable");

	c_frame_in: cover property (CE && push);
	c_overrun: cover property (CE && ovr);
	c_addr_drop: cover property (CE && addr_drop);
	c_two_deep: cover property (s_reg.cnt == `FIFO_FULL ##1 CE && pop);

endmodule : uart_rx
`default_nettype wire

// *** uart_tx_model.sv ***
// serial transmitter model for the remote master on the line
`timescale 1ns/1ps
`default_nettype none
// ****************
// transmitter
// ****************
module uart_tx_model #(
	parameter int BIT_CLKS = 16
) (
	input wire logic clk,
	output var logic line
);
	initial line = 1'b1;
	// stop level is chosen by the caller so a broken frame can be sent
	task automatic send(input logic [8:0] d, input logic nine,
		input logic stop);
		int n;
		n = nine ? 9 : 8;
		@(posedge clk);
		line <= 1'b0;
		repeat (BIT_CLKS - 1) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			line <= d[i];
			repeat (BIT_CLKS - 1) @(posedge clk);
		end
		@(posedge clk);
		line <= stop;
		repeat (BIT_CLKS - 1) @(posedge clk);
		// a full idle bit keeps a low stop apart from the next start
		@(posedge clk);
		line <= 1'b1;
		repeat (BIT_CLKS + 4) @(posedge clk);
	endtask : send
endmodule : uart_tx_model
`default_nettype wire

// *** tb_uart_rx.sv ***
// self-checking bench of the serial receiver
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_cfg.svh"
module tb_uart_rx;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] rd_data;
	logic rx;
	logic irq;
	int failures = 0;
	int checks = 0;
	always #2 ref_clk = ~ref_clk;
	uart_rx uart_rx_i (.REF_CLK(ref_clk), .RESET(reset), .CE(1'b1),
		.ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en),
		.RD_DATA(rd_data), .RX(rx), .IRQ(irq));
	uart_tx_model uart_tx_model_i (.clk(ref_clk), .line(rx));
	// ****************
	// bus and compare
	// ****************
	task automatic chk(input string nm, input logic [7:0] s, e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), rd_data, e);
	endtask : rdc
	task automatic irq_is(input logic e);
		repeat (3) @(posedge ref_clk);
		#1;
		chk("irq", {7'h00, irq}, {7'h00, e});
	endtask : irq_is
	task automatic tx(input logic [8:0] d, input logic nine, stop);
		uart_tx_model_i.send(d, nine, stop);
	endtask : tx
	task automatic final_report;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	// ****************
	// scenarios
	// ****************
	task automatic t_reset;
		rdc(`A_TX_CTRL, 8'h02);
		rdc(`A_IRQ_FLAGS, 8'h00);
		rdc(`A_RX_CTRL, 8'h00);
		rdc(8'h40, 8'h00);
		// low divisor with high speed gives 16 clocks per bit
		wr(`A_BAUD_DIV, 8'h00);
		wr(`A_TX_CTRL, 8'h04);
		rdc(`A_TX_CTRL, 8'h06);
		wr(`A_IRQ_EN, 8'h20);
	endtask : t_reset
	task automatic t_basic;
		wr(`A_RX_CTRL, 8'h80);
		tx(9'h03c, 1'b0, 1'b1);
		rdc(`A_IRQ_FLAGS, 8'h00);
		wr(`A_RX_CTRL, 8'h90);
		tx(9'h0a5, 1'b0, 1'b1);
		rdc(`A_IRQ_FLAGS, 8'h20);
		irq_is(1'b1);
		wr(`A_IRQ_EN, 8'h00);
		irq_is(1'b0);
		wr(`A_IRQ_FLAGS, 8'h00);
		rdc(`A_IRQ_FLAGS, 8'h20);
		rdc(`A_RX_DATA, 8'ha5);
		rdc(`A_IRQ_FLAGS, 8'h00);
		rdc(`A_EVT_STAT, 8'h01);
		wr(`A_EVT_MASK, 8'h01);
		irq_is(1'b1);
		wr(`A_EVT_STAT, 8'h01);
		irq_is(1'b0);
		wr(`A_EVT_MASK, 8'h00);
		wr(`A_IRQ_EN, 8'h20);
	endtask : t_basic
	task automatic t_overrun;
		tx(9'h011, 1'b0, 1'b1);
		tx(9'h022, 1'b0, 1'b1);
		tx(9'h033, 1'b0, 1'b1);
		rdc(`A_RX_CTRL, 8'h92);
		rdc(`A_RX_DATA, 8'h11);
		tx(9'h044, 1'b0, 1'b1);
		rdc(`A_RX_DATA, 8'h22);
		rdc(`A_IRQ_FLAGS, 8'h00);
		rdc(`A_RX_CTRL, 8'h92);
		wr(`A_RX_CTRL, 8'h80);
		wr(`A_RX_CTRL, 8'h90);
		rdc(`A_RX_CTRL, 8'h90);
	endtask : t_overrun
	task automatic t_frame;
		tx(9'h05a, 1'b0, 1'b0);
		tx(9'h06b, 1'b0, 1'b1);
		rdc(`A_RX_CTRL, 8'h94);
		rdc(`A_RX_DATA, 8'h5a);
		rdc(`A_RX_CTRL, 8'h90);
		rdc(`A_RX_DATA, 8'h6b);
	endtask : t_frame
	task automatic t_nine;
		wr(`A_RX_CTRL, 8'hd0);
		tx(9'h155, 1'b1, 1'b1);
		rdc(`A_RX_CTRL, 8'hd1);
		rdc(`A_RX_DATA, 8'h55);
		wr(`A_RX_CTRL, 8'h98);
		tx(9'h077, 1'b0, 1'b1);
		rdc(`A_RX_DATA, 8'h77);
		wr(`A_RX_CTRL, 8'hd8);
		tx(9'h012, 1'b1, 1'b1);
		tx(9'h013, 1'b1, 1'b1);
		rdc(`A_IRQ_FLAGS, 8'h00);
		irq_is(1'b0);
		tx(9'h134, 1'b1, 1'b1);
		rdc(`A_RX_CTRL, 8'hd9);
		irq_is(1'b1);
		rdc(`A_RX_DATA, 8'h34);
		wr(`A_RX_CTRL, 8'hd0);
		tx(9'h056, 1'b1, 1'b1);
		rdc(`A_RX_CTRL, 8'hd0);
		rdc(`A_RX_DATA, 8'h56);
	endtask : t_nine
	initial begin
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		t_reset();
		t_basic();
		t_overrun();
		t_frame();
		t_nine();
		final_report();
	end
	// whole run is some 2700 cycles, so this only cuts a hang short
	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		final_report();
	end
endmodule : tb_uart_rx
`default_nettype wire
